// File: rtl/src_detect_defs.vh
// constants for the input source detection and current limit sequencer
`ifndef SRC_DETECT_DEFS_VH
`define SRC_DETECT_DEFS_VH
// register byte offsets
`define SD_OFF_CTRL 8'h00
`define SD_OFF_EXTERNAL_LIMIT_PIN 8'h04
`define SD_OFF_VLIM 8'h08
`define SD_OFF_STAT 8'h0c
`define SD_OFF_EFF 8'h10
// control register fields
`define SD_CTRL_AUTO 0
`define SD_CTRL_HVA 1
`define SD_CTRL_HVB 2
`define SD_CTRL_FORCE 3
`define SD_CTRL_ABSV 4
`define SD_CTRL_HIZ 5
`define SD_CTRL_OPT 6
`define SD_CTRL_HV12 7
`define SD_CTRL_RST 8'h47
// status register fields
`define SD_STAT_IGOOD 0
`define SD_STAT_PGOOD 1
`define SD_STAT_DONE 2
`define SD_STAT_CODE_LO 3
`define SD_STAT_BUSY 6
// current limit codes, 50 mA per step above 100 mA
`define SD_IL_500 6'h08
`define SD_IL_1000 6'h12
`define SD_IL_1500 6'h1c
`define SD_IL_2000 6'h26
`define SD_IL_2100 6'h28
`define SD_IL_2400 6'h2e
`define SD_IL_3250 6'h3f
`define SD_EXTERNAL_LIMIT_PIN_RST 6'h08
`define SD_VLIM_RST 8'h26
`define SD_VLIM_OFS 8'h06
// source type codes
`define SD_SRC_NONE 3'h0
`define SD_SRC_SDP 3'h1
`define SD_SRC_CDP 3'h2
`define SD_SRC_DCP 3'h3
`define SD_SRC_HV 3'h4
`define SD_SRC_UNK 3'h5
`define SD_SRC_DIV 3'h6
`define SD_SRC_ADAPTER 3'h2
// timing, sized so that the cycle products fit in the 27-bit timer
`define SD_CLK_KHZ 27'h9c40
`define SD_RETRY_MS 27'h7d0
`define SD_DCD_MS 27'h1f4
`define SD_HV_WAIT_MS 27'h3e8
`define SD_SETTLE_CYC 27'h0000003
`endif

// File: rtl/cycle_timer.v
// down counter that times every wait of the detection sequencer
`timescale 1ns/1ps
module cycle_timer #(
  parameter W = 27
) (
  input wire clk, // system clock
  input wire rst_n, // asynchronous reset, active low
  input wire load, // start a new wait
  input wire [W-1:0] value, // cycles to wait
  output wire expired // high once the wait has run out
);
  reg [W-1:0] cnt_q;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= {W{1'b0}};
    end else if (load) begin
      cnt_q <= value;
    end else if (cnt_q != {W{1'b0}}) begin
      cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
    end
  end

  // the sequencer reloads on expiry, so expiry must not depend on load
  assign expired = (cnt_q == {W{1'b0}});
endmodule

// File: rtl/input_source_detect_external_limit_pin.v
// input qualification, source type detection and input limit sequencer
//
// Chosen here: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
`include "src_detect_defs.vh"
module input_source_detect_external_limit_pin #(
  parameter PORT_SELECT_VARIANT = 0,
  parameter [26:0] RETRY_CYC = `SD_RETRY_MS * `SD_CLK_KHZ,
  parameter [26:0] DCD_CYC = `SD_DCD_MS * `SD_CLK_KHZ,
  parameter [26:0] HV_WAIT_CYC = `SD_HV_WAIT_MS * `SD_CLK_KHZ
) (
  input wire hclk, // 40 MHz system clock
  input wire hresetn, // asynchronous reset, active low
  input wire hsel, // ahb slave select
  input wire [31:0] haddr, // ahb address
  input wire [1:0] htrans, // ahb transfer type
  input wire hwrite, // ahb write
  input wire [2:0] hsize, // ahb size, word only
  input wire [31:0] hwdata, // ahb write data
  input wire hready, // ahb bus ready
  output reg hreadyout, // ahb slave ready
  output reg hresp, // ahb response, always okay
  output reg [31:0] hrdata, // ahb read data
  input wire regulator_on, // internal bias regulator is up
  input wire source_qual_ok, // input passes the poor source check
  input wire data_contact, // data contact seen on the lines
  input wire primary_det, // primary detection comparator
  input wire secondary_det, // secondary detection comparator
  input wire hv_ack, // adapter raised its output voltage
  input wire port_select, // port-select pin, high for host port
  input wire window_2v7_dp, // D+ in the 2.7 V window
  input wire window_2v0_dp, // D+ in the 2.0 V window
  input wire window_1v2_dp, // D+ in the 1.2 V window
  input wire window_2v7_dm, // D- in the 2.7 V window
  input wire window_2v0_dm, // D- in the 2.0 V window
  input wire window_1v2_dm, // D- in the 1.2 V window
  input wire [5:0] external_limit_pin, // limit set by the external pin, code
  input wire [7:0] vbus_meas, // measured input voltage, code
  output reg host_int, // interrupt pulse to the host
  output reg power_good_pin_n, // power good pin, active low
  output reg qual_load_en, // pull the qualification load current
  output reg dp_src_en, // primary detection drive on D+
  output reg dm_src_en, // secondary detection drive on D-
  output reg line_current_sink_dp, // current sink on D+
  output reg line_voltage_source_dp, // voltage source on D+
  output reg line_current_sink_dm, // current sink on D-
  output reg line_voltage_source_dm, // voltage source on D-
  output reg [5:0] external_limit_pin_applied, // current limit in force
  output reg [7:0] vlim_applied, // voltage limit in force
  output reg high_impedance_out // input stage held in high impedance
);
  localparam S_IDLE = 4'h0;
  localparam S_QUAL = 4'h1;
  localparam S_RETRY = 4'h2;
  localparam S_READY = 4'h3;
  localparam S_DCD = 4'h4;
  localparam S_PRIM = 4'h5;
  localparam S_SEC = 4'h6;
  localparam S_NONSTD = 4'h7;
  localparam S_HV = 4'h8;
  localparam S_PSEL = 4'h9;
  localparam S_VSET = 4'ha;
  localparam NSYNC = 27;

  function [5:0] min6;
    input [5:0] a;
    input [5:0] b;
    begin
      min6 = (a < b) ? a : b;
    end
  endfunction

  // divider adapter limit from the window comparators, zero when none match
  function [5:0] divider_limit;
    input [5:0] w;
    begin
      case (w)
        6'b100010: divider_limit = `SD_IL_2100;
        6'b001001: divider_limit = `SD_IL_2000;
        6'b010100: divider_limit = `SD_IL_1000;
        6'b100100: divider_limit = `SD_IL_2400;
        default: divider_limit = 6'h00;
      endcase
    end
  endfunction

  reg [NSYNC-1:0] s1_q;
  reg [NSYNC-1:0] s2_q;
  reg [3:0] state_q;
  reg [7:0] ctrl_q;
  reg [5:0] external_limit_pin_q;
  reg [7:0] vlim_q;
  reg [2:0] code_q;
  reg done_q;
  reg igood_q;
  reg pgood_q;
  reg ran_q;
  reg wr_q;
  reg rd_q;
  reg [7:0] addr_q;
  reg ok_q;
  reg tload;
  reg [26:0] tval;
  reg [31:0] rmux;
  wire texp;
  wire reg_on_s;
  wire qual_s;
  wire contact_s;
  wire prim_s;
  wire sec_s;
  wire hvack_s;
  wire psel_s;
  wire [5:0] win_s;
  wire [5:0] ext_s;
  wire [7:0] vbus_s;
  wire [5:0] div_il;
  wire hv_en;
  wire start_det;
  wire take;
  wire mapped;
  wire [7:0] vlim_auto;

  // level inputs from the pins pass two flops before any use
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q <= {NSYNC{1'b0}};
      s2_q <= {NSYNC{1'b0}};
    end else begin
      s1_q <= {vbus_meas, external_limit_pin, window_2v7_dp, window_2v0_dp,
               window_1v2_dp, window_2v7_dm, window_2v0_dm, window_1v2_dm,
               port_select, hv_ack, secondary_det, primary_det, data_contact,
               source_qual_ok, regulator_on};
      s2_q <= s1_q;
    end
  end

  assign reg_on_s = s2_q[0];
  assign qual_s = s2_q[1];
  assign contact_s = s2_q[2];
  assign prim_s = s2_q[3];
  assign sec_s = s2_q[4];
  assign hvack_s = s2_q[5];
  assign psel_s = s2_q[6];
  assign win_s = s2_q[12:7];
  assign ext_s = s2_q[18:13];
  assign vbus_s = s2_q[26:19];
  assign div_il = divider_limit(win_s);
  assign hv_en = ctrl_q[`SD_CTRL_HVA] | ctrl_q[`SD_CTRL_HVB];
  assign start_det = (ctrl_q[`SD_CTRL_AUTO] && !ran_q) || ctrl_q[`SD_CTRL_FORCE];
  assign vlim_auto = (vbus_s > `SD_VLIM_OFS) ? vbus_s - `SD_VLIM_OFS : 8'h00;
  assign take = hsel && htrans[1] && hready;
  assign mapped = (addr_q[1:0] == 2'b00) && (addr_q <= `SD_OFF_EFF) && ok_q;

  // timer loads: settle times for drive changes, long waits otherwise
  always @* begin
    tload = 1'b0;
    tval = `SD_SETTLE_CYC;
    case (state_q)
      S_IDLE: tload = reg_on_s;
      S_QUAL: begin
        if (texp && !qual_s) begin
          tload = 1'b1;
          tval = RETRY_CYC;
        end
      end
      S_RETRY: tload = texp;
      S_READY: begin
        if (!ran_q || ctrl_q[`SD_CTRL_FORCE]) begin
          tload = 1'b1;
          tval = (PORT_SELECT_VARIANT != 0) ? `SD_SETTLE_CYC : DCD_CYC;
        end
      end
      S_DCD: tload = contact_s || texp;
      S_PRIM: tload = texp && prim_s;
      S_SEC: begin
        if (texp && sec_s && hv_en) begin
          tload = 1'b1;
          tval = HV_WAIT_CYC;
        end
      end
      default: tload = 1'b0;
    endcase
  end

  cycle_timer #(
    .W(27)
  ) u_timer (
    .clk(hclk),
    .rst_n(hresetn),
    .load(tload),
    .value(tval),
    .expired(texp)
  );

  always @* begin
    rmux = 32'h00000000;
    case (addr_q)
      `SD_OFF_CTRL: rmux[7:0] = ctrl_q;
      `SD_OFF_EXTERNAL_LIMIT_PIN: rmux[5:0] = external_limit_pin_q;
      `SD_OFF_VLIM: rmux[7:0] = vlim_q;
      `SD_OFF_STAT: rmux[6:0] = {state_q != S_READY && state_q != S_IDLE,
                                 code_q, done_q, pgood_q, igood_q};
      `SD_OFF_EFF: rmux[5:0] = external_limit_pin_applied;
      default: rmux = 32'h00000000;
    endcase
  end

  // common end of a detection run
  task finish;
    input [5:0] il;
    input [2:0] code;
    begin
      external_limit_pin_q <= il;
      code_q <= code;
      done_q <= 1'b1;
      // power good and single interrupt pulse
      pgood_q <= 1'b1;
      host_int <= 1'b1;
      ctrl_q[`SD_CTRL_FORCE] <= 1'b0;
      {line_voltage_source_dm, line_current_sink_dm} <= 2'b00;
      {line_voltage_source_dp, line_current_sink_dp} <= 2'b00;
      {dm_src_en, dp_src_en} <= 2'b00;
      state_q <= S_VSET;
    end
  endtask

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      addr_q <= 8'h00;
      ok_q <= 1'b0;
      ctrl_q <= `SD_CTRL_RST;
      external_limit_pin_q <= `SD_EXTERNAL_LIMIT_PIN_RST;
      vlim_q <= `SD_VLIM_RST;
      code_q <= `SD_SRC_NONE;
      done_q <= 1'b0;
      igood_q <= 1'b0;
      pgood_q <= 1'b0;
      ran_q <= 1'b0;
      state_q <= S_IDLE;
      host_int <= 1'b0;
      power_good_pin_n <= 1'b1;
      qual_load_en <= 1'b0;
      dp_src_en <= 1'b0;
      dm_src_en <= 1'b0;
      line_current_sink_dp <= 1'b0;
      line_voltage_source_dp <= 1'b0;
      line_current_sink_dm <= 1'b0;
      line_voltage_source_dm <= 1'b0;
      external_limit_pin_applied <= `SD_EXTERNAL_LIMIT_PIN_RST;
      vlim_applied <= `SD_VLIM_RST;
      high_impedance_out <= 1'b0;
    end else begin
      host_int <= 1'b0;
      // reads take one wait cycle so that a write just before is seen
      wr_q <= take && hwrite;
      rd_q <= take && !hwrite;
      if (take) begin
        addr_q <= haddr[7:0];
        ok_q <= (haddr[31:8] == 24'h000000) && (hsize == 3'h2);
        hreadyout <= hwrite;
      end
      if (rd_q) begin
        hrdata <= mapped ? rmux : 32'h00000000;
        hreadyout <= 1'b1;
      end
      if (wr_q && mapped) begin
        case (addr_q)
          // force bit only sets from software; hardware clears it
          `SD_OFF_CTRL: ctrl_q <= hwdata[7:0] | (ctrl_q & 8'h08);
          // host may overwrite the limit at any time
          `SD_OFF_EXTERNAL_LIMIT_PIN: external_limit_pin_q <= hwdata[5:0];
          // host value used only with absolute select
          `SD_OFF_VLIM: if (ctrl_q[`SD_CTRL_ABSV]) vlim_q <= hwdata[7:0];
          default: ;
        endcase
      end
      // lower of register and pin, whatever the optimizer setting
      external_limit_pin_applied <= min6(external_limit_pin_q, ext_s);
      vlim_applied <= vlim_q;
      high_impedance_out <= ctrl_q[`SD_CTRL_HIZ];
      // power good pin only driven low on the port-select variant
      power_good_pin_n <= !(pgood_q && (PORT_SELECT_VARIANT != 0));
      case (state_q)
        S_IDLE: begin
          if (reg_on_s) begin
            qual_load_en <= 1'b1;
            state_q <= S_QUAL;
          end
        end
        S_QUAL: begin
          if (texp) begin
            qual_load_en <= 1'b0;
            if (qual_s) begin
              igood_q <= 1'b1;
              host_int <= 1'b1;
              state_q <= S_READY;
            end else begin
              state_q <= S_RETRY;
            end
          end
        end
        S_RETRY: begin
          // retry after the 2 s wait
          if (texp) begin
            qual_load_en <= 1'b1;
            state_q <= S_QUAL;
          end
        end
        S_READY: begin
          if (!ran_q || ctrl_q[`SD_CTRL_FORCE]) begin
            ran_q <= 1'b1;
            if (!start_det) begin
              state_q <= S_VSET;
            end else if (PORT_SELECT_VARIANT != 0) begin
              state_q <= S_PSEL;
            end else begin
              state_q <= S_DCD;
            end
          end
        end
        S_DCD: begin
          if (contact_s) begin
            dp_src_en <= 1'b1;
            state_q <= S_PRIM;
          end else if (texp) begin
            // contact timeout moves to divider detection
            state_q <= S_NONSTD;
          end
        end
        S_PRIM: begin
          // sampled only after the drive settles
          if (texp) begin
            dp_src_en <= 1'b0;
            if (prim_s) begin
              dm_src_en <= 1'b1;
              state_q <= S_SEC;
            end else begin
              finish(`SD_IL_500, `SD_SRC_SDP);
            end
          end
        end
        S_SEC: begin
          if (texp) begin
            dm_src_en <= 1'b0;
            if (!sec_s) begin
              finish(`SD_IL_1500, `SD_SRC_CDP);
            end else if (hv_en) begin
              // line drive selects the requested voltage
              line_current_sink_dp <= ctrl_q[`SD_CTRL_HV12];
              line_voltage_source_dm <= ctrl_q[`SD_CTRL_HV12];
              line_voltage_source_dp <= !ctrl_q[`SD_CTRL_HV12];
              line_current_sink_dm <= !ctrl_q[`SD_CTRL_HV12];
              state_q <= S_HV;
            end else begin
              finish(`SD_IL_3250, `SD_SRC_DCP);
            end
          end
        end
        S_NONSTD: begin
          if (texp) begin
            if (div_il != 6'h00) begin
              finish(div_il, `SD_SRC_DIV);
            end else begin
              finish(`SD_IL_500, `SD_SRC_UNK);
            end
          end
        end
        S_HV: begin
          // handshake success, else stay a plain charging port
          if (hvack_s) begin
            finish(`SD_IL_1500, `SD_SRC_HV);
          end else if (texp) begin
            finish(`SD_IL_3250, `SD_SRC_DCP);
          end
        end
        S_PSEL: begin
          if (texp) begin
            if (psel_s) begin
              finish(`SD_IL_500, `SD_SRC_SDP);
            end else begin
              finish(`SD_IL_3250, `SD_SRC_ADAPTER);
            end
          end
        end
        S_VSET: begin
          // second pulse, one idle cycle after the result pulse
          if (!host_int) begin
            // algorithm owns the limit unless absolute select is set
            if (!ctrl_q[`SD_CTRL_ABSV]) vlim_q <= vlim_auto;
            host_int <= 1'b1;
            state_q <= S_READY;
          end
        end
        default: state_q <= S_IDLE;
      endcase
      // results stay; unplug clears only the live flags and drive
      if (!reg_on_s && state_q != S_IDLE) begin
        state_q <= S_IDLE;
        igood_q <= 1'b0;
        pgood_q <= 1'b0;
        ran_q <= 1'b0;
        qual_load_en <= 1'b0;
        {dp_src_en, dm_src_en} <= 2'b00;
        {line_current_sink_dp, line_voltage_source_dp} <= 2'b00;
        {line_current_sink_dm, line_voltage_source_dm} <= 2'b00;
        host_int <= 1'b0;
      end
      // a software set in the clearing cycle wins
      if (wr_q && mapped && addr_q == `SD_OFF_CTRL && hwdata[`SD_CTRL_FORCE]) begin
        ctrl_q[`SD_CTRL_FORCE] <= 1'b1;
      end
    end
  end
endmodule

// File: tb/src_detect_checker_assertions.sv
// concurrent checks on the ports of the source detection sequencer
`timescale 1ns/1ps
module src_detect_checker #(
  parameter PORT_SELECT_VARIANT = 0
) (
  input wire hclk, // system clock
  input wire hresetn, // asynchronous reset, active low
  input wire hsel, // ahb slave select
  input wire [1:0] htrans, // ahb transfer type
  input wire hwrite, // ahb write
  input wire regulator_on, // bias regulator up
  input wire [5:0] external_limit_pin, // pin limit code
  input wire host_int, // interrupt pulse
  input wire power_good_pin_n, // power good pin
  input wire dp_src_en, // primary drive
  input wire dm_src_en, // secondary drive
  input wire line_current_sink_dp, // sink on D+
  input wire line_voltage_source_dp, // source on D+
  input wire line_current_sink_dm, // sink on D-
  input wire line_voltage_source_dm, // source on D-
  input wire [5:0] external_limit_pin_applied, // limit in force
  input wire [7:0] vlim_applied // voltage limit in force
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire wr_take = hsel & hwrite & htrans[1];
  wire hv_drive = line_current_sink_dp | line_voltage_source_dp;
  logic [2:0] pin_cnt_q;
  logic [5:0] pin_last_q;
  // the pin passes two sync flops, so only a settled pin is compared
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_cnt_q <= 3'h0;
      pin_last_q <= 6'h00;
    end else begin
      pin_last_q <= external_limit_pin;
      if (pin_last_q != external_limit_pin) pin_cnt_q <= 3'h0;
      else if (pin_cnt_q != 3'h7) pin_cnt_q <= pin_cnt_q + 3'h1;
    end
  end
  property p_one_pulse; host_int |=> !host_int; endproperty
  a_one_pulse: assert property (p_one_pulse) else $error("interrupt longer than one cycle");
  property p_pg_pin; PORT_SELECT_VARIANT == 0 |-> power_good_pin_n; endproperty
  a_pg_pin: assert property (p_pg_pin) else $error("power good pin low in line variant");
  property p_det_after_reg; $rose(dp_src_en) |-> $past(regulator_on, 4); endproperty
  a_det_after_reg: assert property (p_det_after_reg) else $error("detection without regulator");
  property p_hv_pair;
    line_current_sink_dp == line_voltage_source_dm && line_voltage_source_dp == line_current_sink_dm
      && !(line_current_sink_dp && line_voltage_source_dp);
  endproperty
  a_hv_pair: assert property (p_hv_pair) else $error("handshake drive pattern wrong");
  property p_hv_after_dcp; $rose(hv_drive) |-> $past(dm_src_en) || $past(dm_src_en, 2); endproperty
  a_hv_after_dcp: assert property (p_hv_after_dcp) else $error("handshake without port check");
  property p_external_limit_pin_cap;
    pin_last_q == external_limit_pin && pin_cnt_q >= 3'h4 |-> external_limit_pin_applied <= external_limit_pin;
  endproperty
  a_external_limit_pin_cap: assert property (p_external_limit_pin_cap) else $error("applied limit above pin limit");
  property p_vlim_cause;
    $changed(vlim_applied) |-> host_int || $past(host_int) || $past(wr_take, 2) || $past(wr_take, 3);
  endproperty
  a_vlim_cause: assert property (p_vlim_cause) else $error("voltage limit moved by itself");
  property p_dp_hold; $rose(dp_src_en) |-> dp_src_en [*3]; endproperty
  a_dp_hold: assert property (p_dp_hold) else $error("primary drive too short");
  property p_dm_hold; $rose(dm_src_en) |-> dm_src_en [*3] ##0 !dp_src_en; endproperty
  a_dm_hold: assert property (p_dm_hold) else $error("secondary drive too short");
endmodule
bind input_source_detect_external_limit_pin src_detect_checker #(.PORT_SELECT_VARIANT(PORT_SELECT_VARIANT))
  src_detect_checker_i (.hclk, .hresetn, .hsel, .htrans, .hwrite, .regulator_on,
  .external_limit_pin, .host_int, .power_good_pin_n, .dp_src_en, .dm_src_en,
  .line_current_sink_dp, .line_voltage_source_dp, .line_current_sink_dm,
  .line_voltage_source_dm, .external_limit_pin_applied, .vlim_applied);

// File: tb/usb_source_model.sv
// model of the usb port or charging adapter on the data lines
`timescale 1ns/1ps
module usb_source_model (
  input wire logic hclk, // system clock
  input wire logic [3:0] kind, // 1 sdp 2 cdp 3 dcp 4 hv 5 unknown 6-9 divider
  input wire logic hv12, // adapter wants the 12 V pattern
  input wire logic [3:0] ack_delay, // answer latency of the adapter
  input wire logic dp_src_en, // primary drive
  input wire logic dm_src_en, // secondary drive
  input wire logic line_current_sink_dp, // sink on D+
  input wire logic line_voltage_source_dp, // source on D+
  input wire logic line_current_sink_dm, // sink on D-
  input wire logic line_voltage_source_dm, // source on D-
  output logic data_contact, // contact seen
  output logic primary_det, // primary comparator
  output logic secondary_det, // secondary comparator
  output logic hv_ack, // output raised
  output logic [5:0] win // windows, D+ 2v7 2v0 1v2 then D-
);
  logic [4:0] hv_cnt_q = 5'h00;
  logic pair_ok;
  assign pair_ok = hv12 ?
    (line_current_sink_dp & line_voltage_source_dm & !line_voltage_source_dp & !line_current_sink_dm) :
    (line_voltage_source_dp & line_current_sink_dm & !line_current_sink_dp & !line_voltage_source_dm);
  always @(posedge hclk) begin
    hv_cnt_q <= (kind == 4'h4 && pair_ok) ? hv_cnt_q + {4'h0, hv_cnt_q != 5'h1f} : 5'h00;
  end
  assign hv_ack = hv_cnt_q > {1'b0, ack_delay};
  assign data_contact = kind >= 4'h1 && kind <= 4'h4;
  assign primary_det = dp_src_en && kind >= 4'h2 && kind <= 4'h4;
  assign secondary_det = dm_src_en && kind >= 4'h3 && kind <= 4'h4;
  assign win = kind == 4'h6 ? 6'b100010 : kind == 4'h7 ? 6'b001001 :
    kind == 4'h8 ? 6'b010100 : kind == 4'h9 ? 6'b100100 : 6'h00;
endmodule

// File: tb/test_input_source_detect_external_limit_pin.sv
// self-checking testbench of the source detection sequencer
`timescale 1ns/1ps
`include "src_detect_defs.vh"
module test_input_source_detect_external_limit_pin;
  logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, port_select = 1'h0, hv12 = 1'h0;
  logic regulator_on = 1'h0, source_qual_ok = 1'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, lf = 32'hf3269d77;
  logic [3:0] kind = 4'h0, ack_dly = 4'h0, k;
  logic [5:0] external_limit_pin = 6'h3f, win;
  logic [7:0] vbus_meas = 8'h50, c;
  logic [8:0] e;
  int n_errors = 0, compares = 0, n_int = 0, base;
  wire hreadyout, hresp, host_int, power_good_pin_n, qual_load_en, dp_src_en, dm_src_en;
  wire line_current_sink_dp, line_voltage_source_dp, line_current_sink_dm, line_voltage_source_dm;
  wire high_impedance_out, data_contact, primary_det, secondary_det, hv_ack;
  wire [31:0] hrdata;
  wire [5:0] external_limit_pin_applied;
  wire [7:0] vlim_applied;
  input_source_detect_external_limit_pin #(.RETRY_CYC(27'h32), .DCD_CYC(27'h28), .HV_WAIT_CYC(27'h3c))
    input_source_detect_external_limit_pin_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .regulator_on, .source_qual_ok,
    .data_contact, .primary_det, .secondary_det, .hv_ack, .port_select,
    .window_2v7_dp(win[5]), .window_2v0_dp(win[4]), .window_1v2_dp(win[3]),
    .window_2v7_dm(win[2]), .window_2v0_dm(win[1]), .window_1v2_dm(win[0]),
    .external_limit_pin, .vbus_meas, .host_int, .power_good_pin_n, .qual_load_en, .dp_src_en,
    .dm_src_en, .line_current_sink_dp, .line_voltage_source_dp, .line_current_sink_dm,
    .line_voltage_source_dm, .external_limit_pin_applied, .vlim_applied, .high_impedance_out);
  usb_source_model usb_source_model_i (.hclk, .kind, .hv12, .ack_delay(ack_dly), .dp_src_en,
    .dm_src_en, .line_current_sink_dp, .line_voltage_source_dp, .line_current_sink_dm,
    .line_voltage_source_dm, .data_contact, .primary_det, .secondary_det, .hv_ack, .win);
  always #12.5 hclk = !hclk;
  always @(posedge hclk) if (host_int === 1'b1) n_int <= n_int + 1;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [5:0] min6(input logic [5:0] a, input logic [5:0] b);
    return a < b ? a : b;
  endfunction
  function automatic logic [7:0] vexp(input logic [7:0] v);
    return v < 8'h06 ? 8'h00 : v - 8'h06;
  endfunction
  function automatic logic [8:0] exp_res(input logic [3:0] kd, input logic hv);
    case (kd)
      4'h1: return {3'h1, 6'h08};
      4'h2: return {3'h2, 6'h1c};
      4'h4: return hv ? {3'h4, 6'h1c} : {3'h3, 6'h3f};
      4'h5: return {3'h5, 6'h08};
      4'h6: return {3'h6, 6'h28};
      4'h7: return {3'h6, 6'h26};
      4'h8: return {3'h6, 6'h12};
      4'h9: return {3'h6, 6'h2e};
      default: return {3'h3, 6'h3f};
    endcase
  endfunction
  task check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  // master holds each phase until hready is sampled high
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task wait_int(input int n);
    for (int i = 0; i < 3000 && n_int < n; i++) @(posedge hclk);
    check(n_int >= n, 32'h1, "interrupt count");
  endtask
  task plug(input logic [3:0] kd, input logic [7:0] ctrl, input int npulse, input logic late);
    regulator_on <= 1'b0;
    source_qual_ok <= 1'b0;
    repeat (10) @(posedge hclk);
    bus(1'b1, `SD_OFF_CTRL, {24'h0, ctrl});
    lf = lfsr(lf);
    kind <= kd;
    vbus_meas <= lf[7:0];
    ack_dly <= lf[11:8];
    base = n_int;
    regulator_on <= 1'b1;
    source_qual_ok <= !late;
    if (late) begin
      repeat (80) @(posedge hclk);
      check(n_int, base, "pulse while source is poor");
      source_qual_ok <= 1'b1;
    end
    wait_int(base + npulse);
    repeat (20) @(posedge hclk);
    check(n_int, base + npulse, "pulse count");
    check(qual_load_en, 1'b0, "qualification load off");
    bus(1'b0, `SD_OFF_VLIM, 32'h0);
    check(rd, {24'h0, vexp(vbus_meas)}, "voltage limit");
  endtask
  task finish_test;
    $display("comparisons %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge hclk);
    n_errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    finish_test;
  end
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, `SD_OFF_CTRL, 32'h0);
    check(rd, 32'h47, "control reset");
    check(hresp, 1'b0, "response okay");
    bus(1'b0, `SD_OFF_EXTERNAL_LIMIT_PIN, 32'h0);
    check(rd, 32'h08, "limit reset");
    bus(1'b0, `SD_OFF_STAT, 32'h0);
    check(rd, 32'h0, "status reset");
    bus(1'b1, 8'h14, 32'hffffffff);
    bus(1'b0, 8'h14, 32'h0);
    check(rd, 32'h0, "unmapped read");
    $display("test reset done");
    for (int i = 0; i < 11; i++) begin
      k = i < 9 ? 4'(i + 1) : 4'h4;
      c = i == 9 ? 8'hc7 : (i == 10 ? 8'h41 : 8'h47);
      hv12 <= c[7];
      plug(k, c, 3, i == 0);
      e = exp_res(k, c[1] | c[2]);
      bus(1'b0, `SD_OFF_STAT, 32'h0);
      check(rd[6:0], {1'b0, e[8:6], 3'h7}, "status after detection");
      bus(1'b0, `SD_OFF_EXTERNAL_LIMIT_PIN, 32'h0);
      check(rd, {26'h0, e[5:0]}, "limit after detection");
    end
    $display("test detection done");
    plug(4'h1, 8'h46, 2, 1'b0);
    bus(1'b0, `SD_OFF_STAT, 32'h0);
    check(rd[5:2], 4'h7, "code kept with auto off");
    bus(1'b0, `SD_OFF_EXTERNAL_LIMIT_PIN, 32'h0);
    check(rd, 32'h3f, "limit kept with auto off");
    base = n_int;
    bus(1'b1, `SD_OFF_CTRL, 32'h4e);
    wait_int(base + 2);
    bus(1'b0, `SD_OFF_CTRL, 32'h0);
    check(rd, 32'h46, "force bit cleared");
    bus(1'b0, `SD_OFF_STAT, 32'h0);
    check(rd[5:2], 4'h3, "forced result");
    $display("test force done");
    for (int i = 0; i < 8; i++) begin
      lf = lfsr(lf);
      bus(1'b1, `SD_OFF_EXTERNAL_LIMIT_PIN, lf);
      external_limit_pin <= lf[13:8];
      repeat (6) @(posedge hclk);
      check(external_limit_pin_applied, min6(lf[5:0], lf[13:8]), "applied limit");
      bus(1'b0, `SD_OFF_EFF, 32'h0);
      check(rd, {26'h0, min6(lf[5:0], lf[13:8])}, "applied limit read");
    end
    $display("test limit done");
    bus(1'b1, `SD_OFF_CTRL, 32'h76);
    bus(1'b1, `SD_OFF_VLIM, 32'ha5);
    bus(1'b0, `SD_OFF_VLIM, 32'h0);
    check(rd, 32'ha5, "absolute voltage limit");
    check(vlim_applied, 8'ha5, "voltage limit in force");
    check(high_impedance_out, 1'b1, "high impedance on");
    bus(1'b1, `SD_OFF_CTRL, 32'h46);
    bus(1'b1, `SD_OFF_VLIM, 32'h11);
    bus(1'b0, `SD_OFF_VLIM, 32'h0);
    check(rd, 32'ha5, "voltage limit read only");
    check(high_impedance_out, 1'b0, "high impedance off");
    $display("test voltage limit done");
    finish_test;
  end
endmodule
